// file: rtl/sfli_pkg.sv
// shared constants, types and register map for the fault indicator block
package sfli_pkg;
  // register byte offsets
  localparam logic [7:0] SFLI_CTRL_OFS = 8'h00;    // mode, program state, user indicator
  localparam logic [7:0] SFLI_FAULT_OFS = 8'h04;   // fault inputs from software
  localparam logic [7:0] SFLI_LATCH_OFS = 8'h08;   // fault latch time in cycles
  localparam logic [7:0] SFLI_STATUS_OFS = 8'h0c;  // live state, read only
  localparam logic [7:0] SFLI_IRQ_OFS = 8'h10;     // sticky events, cleared by read
  localparam logic [7:0] SFLI_MASK_OFS = 8'h14;    // interrupt mask
  localparam logic [7:0] SFLI_UPER_OFS = 8'h18;    // user indicator flash half period
  // control fields
  localparam int SFLI_MODE_LSB = 0;        // 3-bit module mode
  localparam int SFLI_RUN_BIT = 3;         // user program running
  localparam int SFLI_LOADED_BIT = 4;      // user program present
  localparam int SFLI_UEN_BIT = 5;         // user indicator enable
  localparam int SFLI_UVAL_BIT = 6;        // user indicator value from state machine
  localparam int SFLI_UFLASH_BIT = 7;      // user indicator flashes when on
  // fault fields
  localparam int SFLI_SELF_BIT = 0;        // self-diagnostic fault present
  localparam int SFLI_KIND_LSB = 1;        // 2-bit self fault kind
  localparam int SFLI_NFLASH_LSB = 4;      // 4-bit flash count for internal errors
  localparam int SFLI_UCFG_BIT = 8;        // user-configured diagnostic fault
  localparam int SFLI_AERR_BIT = 9;        // analog configuration error
  localparam int SFLI_IOV_BIT = 12;        // i/o fault present
  localparam int SFLI_IOTYPE_LSB = 13;     // 3-bit i/o fault type code
  localparam int SFLI_IOCH_LSB = 16;       // 5-bit i/o channel
  localparam int SFLI_DOSTK_BIT = 24;      // both output switches stuck closed
  // interrupt event bits
  localparam int SFLI_EV_FAILSAFE = 0;
  localparam int SFLI_EV_IOFAULT = 1;
  localparam int SFLI_EV_OPEN = 2;
  localparam int SFLI_EV_W = 3;
  // reset values
  localparam logic [31:0] SFLI_LATCH_RST = 32'h0000_0028;
  localparam logic [31:0] SFLI_UPER_RST = 32'h0098_9680;
  localparam logic [2:0] SFLI_MIN_INTERNAL = 3'h4;  // internal error shows at least four flashes
  // flash code counts for fault kinds
  localparam logic [3:0] SFLI_CNT_USER = 4'h1;
  localparam logic [3:0] SFLI_CNT_TEMP = 4'h2;
  localparam logic [3:0] SFLI_CNT_POWER = 4'h3;
  // timing in ms, converted to 40 MHz cycles
  localparam int SFLI_CLK_KHZ = 40000;
  localparam int SFLI_SHORT_MS = 200;
  localparam int SFLI_LONG_MS = 600;
  localparam int SFLI_PAUSE_MS = 1500;
  localparam int SFLI_STAT_MS = 500;
  localparam int SFLI_SHORT_CYC = SFLI_SHORT_MS * SFLI_CLK_KHZ;
  localparam int SFLI_LONG_CYC = SFLI_LONG_MS * SFLI_CLK_KHZ;
  localparam int SFLI_PAUSE_CYC = SFLI_PAUSE_MS * SFLI_CLK_KHZ;
  localparam int SFLI_STAT_CYC = SFLI_STAT_MS * SFLI_CLK_KHZ;

  // module operating modes
  typedef enum logic [2:0] {
    SFLI_M_OPER = 3'h0,
    SFLI_M_VERIFY = 3'h1,
    SFLI_M_DOWNLOAD = 3'h2,
    SFLI_M_UPGRADE = 3'h3,
    SFLI_M_OFF = 3'h4
  } sfli_mode_type;

  // self-diagnostic fault kinds
  typedef enum logic [1:0] {
    SFLI_K_INTERNAL = 2'h0,
    SFLI_K_TEMP = 2'h1,
    SFLI_K_POWER = 2'h2
  } sfli_kind_type;

  // query answer for status readers
  typedef enum logic [1:0] {
    SFLI_Q_OK = 2'h0,
    SFLI_Q_INTERNAL = 2'h1,
    SFLI_Q_TEMP = 2'h2
  } sfli_query_type;

  // apb request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sfli_apb_req_type;

  // the four panel indicators
  typedef struct packed {
    logic supply_status_indicator;
    logic internal_fault_indicator;
    logic io_fault_indicator;
    logic user_indicator;
  } sfli_leds_type;

  // flash sequencer states
  typedef enum logic [4:0] {
    SFLI_S_IDLE = 5'b00001,
    SFLI_S_ON1 = 5'b00010,
    SFLI_S_OFF1 = 5'b00100,
    SFLI_S_ON2 = 5'b01000,
    SFLI_S_PAUSE = 5'b10000
  } sfli_seq_type;
endpackage

// file: rtl/sfli_top.sv
// fault reaction and front panel indicator logic with apb registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module sfli_top
  import sfli_pkg::*;
#(
  parameter int SHORT_CYC = SFLI_SHORT_CYC,
  parameter int LONG_CYC = SFLI_LONG_CYC,
  parameter int PAUSE_CYC = SFLI_PAUSE_CYC,
  parameter int STAT_CYC = SFLI_STAT_CYC,
  parameter int CHAN_W = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sfli_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output sfli_leds_type leds,
  output logic fail_safe,
  output logic low_low_force,
  output sfli_query_type query_status,
  output logic open_circuit_fault,
  output logic irq
);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [31:0] ctrl_r, fault_r, latch_r, uper_r;
  logic [SFLI_EV_W-1:0] irq_r, mask_r, events;
  logic acc, wr, rd, hit;
  logic [31:0] status_w;

  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign rd = acc & ~apb_req.pwrite;
  assign pready = 1'b1;
  assign hit = (apb_req.paddr == SFLI_CTRL_OFS) | (apb_req.paddr == SFLI_FAULT_OFS) |
               (apb_req.paddr == SFLI_LATCH_OFS) | (apb_req.paddr == SFLI_STATUS_OFS) |
               (apb_req.paddr == SFLI_IRQ_OFS) | (apb_req.paddr == SFLI_MASK_OFS) |
               (apb_req.paddr == SFLI_UPER_OFS);
  // unmapped addresses answer with an error, writes there are dropped
  assign pslverr = acc & ~hit;

  // writable configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= 32'h0000_0000;
      fault_r <= 32'h0000_0000;
      latch_r <= SFLI_LATCH_RST;
      mask_r <= '0;
      uper_r <= SFLI_UPER_RST;
    end
    else if (wr)
    begin
      case (apb_req.paddr)
        SFLI_CTRL_OFS: ctrl_r <= apb_req.pwdata;
        SFLI_FAULT_OFS: fault_r <= apb_req.pwdata;
        SFLI_LATCH_OFS: latch_r <= apb_req.pwdata;
        SFLI_UPER_OFS: uper_r <= apb_req.pwdata;
        SFLI_MASK_OFS: mask_r <= apb_req.pwdata[SFLI_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // fault latching
  // ----------------------------------------
  sfli_mode_type mode;
  logic self_now, io_now, ucfg_now, self_r, io_r, ucfg_r;
  logic [31:0] hold_cnt_r;
  logic [1:0] kind_r;
  logic [3:0] nflash_r;
  logic [2:0] iotype_r;
  logic [CHAN_W-1:0] ioch_r;

  assign mode = sfli_mode_type'(ctrl_r[SFLI_MODE_LSB +: 3]);
  assign self_now = fault_r[SFLI_SELF_BIT] | fault_r[SFLI_AERR_BIT];
  assign ucfg_now = fault_r[SFLI_UCFG_BIT];
  assign io_now = fault_r[SFLI_IOV_BIT];

  // a fault stays until it is gone and the latch timer has run out;
  // mode changes do not touch this state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      self_r <= 1'b0;
      io_r <= 1'b0;
      ucfg_r <= 1'b0;
      hold_cnt_r <= 32'h0000_0000;
      kind_r <= 2'h0;
      nflash_r <= 4'h0;
      iotype_r <= 3'h0;
      ioch_r <= '0;
    end
    else if (self_now | io_now | ucfg_now)
    begin
      hold_cnt_r <= latch_r;
      self_r <= self_r | self_now;
      io_r <= io_r | io_now;
      ucfg_r <= ucfg_r | ucfg_now;
      if (self_now)
      begin
        kind_r <= fault_r[SFLI_KIND_LSB +: 2];
        nflash_r <= fault_r[SFLI_NFLASH_LSB +: 4];
      end
      if (io_now)
      begin
        iotype_r <= fault_r[SFLI_IOTYPE_LSB +: 3];
        ioch_r <= fault_r[SFLI_IOCH_LSB +: CHAN_W];
      end
    end
    else if (hold_cnt_r != 32'h0000_0000)
      hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
    else
    begin
      self_r <= 1'b0;
      io_r <= 1'b0;
      ucfg_r <= 1'b0;
    end
  end

  assign fail_safe = self_r | ucfg_r;
  assign low_low_force = fault_r[SFLI_AERR_BIT];
  assign open_circuit_fault = fault_r[SFLI_DOSTK_BIT];

  always_comb
  begin
    if (!self_r)
      query_status = SFLI_Q_OK;
    else if (kind_r == SFLI_K_TEMP)
      query_status = SFLI_Q_TEMP;
    else
      query_status = SFLI_Q_INTERNAL;
  end

  // ----------------------------------------
  // flash code sequencers
  // ----------------------------------------
  logic [3:0] int_cnt;
  logic [CHAN_W:0] io_a, io_b; // one wider than the channel field, so the top channel still fits

  always_comb
  begin
    if (ucfg_r & ~self_r)
      int_cnt = SFLI_CNT_USER;
    else if (kind_r == SFLI_K_TEMP)
      int_cnt = SFLI_CNT_TEMP;
    else if (kind_r == SFLI_K_POWER)
      int_cnt = SFLI_CNT_POWER;
    // more than three, at least four
    else if (nflash_r < 4'(SFLI_MIN_INTERNAL))
      int_cnt = 4'(SFLI_MIN_INTERNAL);
    else
      int_cnt = nflash_r;
  end
  assign io_a = (CHAN_W+1)'(iotype_r);
  assign io_b = (CHAN_W+1)'(ioch_r) + (CHAN_W+1)'(1);

  logic [1:0] seq_on;
  logic [1:0] seq_act;
  logic [CHAN_W:0] seq_a [2];
  logic [CHAN_W:0] seq_b [2];
  assign seq_act = {io_r, fail_safe};
  assign seq_a[0] = (CHAN_W+1)'(int_cnt);
  assign seq_b[0] = '0;
  assign seq_a[1] = io_a;
  assign seq_b[1] = io_b;

  // one sequencer each: group a of short flashes, pause, group b of long flashes
  // (none for the internal one, whose b is zero), pause, then again while the fault stands
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_seq
      sfli_seq_type st_r;
      logic [31:0] tm_r;
      logic [CHAN_W:0] n_r;
      logic phase_r;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          st_r <= SFLI_S_IDLE;
          tm_r <= 32'h0000_0000;
          n_r <= '0;
          phase_r <= 1'b0;
        end
        else if (!seq_act[g])
        begin
          st_r <= SFLI_S_IDLE;
          tm_r <= 32'h0000_0000;
          n_r <= '0;
          phase_r <= 1'b0;
        end
        else if (tm_r != 32'h0000_0000)
          tm_r <= tm_r - 32'h0000_0001;
        else
        begin
          case (st_r)
            SFLI_S_IDLE, SFLI_S_PAUSE:
            begin
              if (!phase_r || seq_b[g] != '0)
              begin
                st_r <= SFLI_S_ON1;
                n_r <= phase_r ? seq_b[g] : seq_a[g];
                tm_r <= 32'(phase_r ? LONG_CYC : SHORT_CYC);
              end
              else
              begin
                phase_r <= 1'b0;
                st_r <= SFLI_S_PAUSE;
                tm_r <= 32'(PAUSE_CYC);
              end
            end
            SFLI_S_ON1, SFLI_S_ON2:
            begin
              st_r <= SFLI_S_OFF1;
              n_r <= n_r - (CHAN_W+1)'(1);
              tm_r <= 32'(SHORT_CYC);
            end
            SFLI_S_OFF1:
            begin
              if (n_r != '0)
              begin
                st_r <= SFLI_S_ON2;
                tm_r <= 32'(phase_r ? LONG_CYC : SHORT_CYC);
              end
              else
              begin
                st_r <= SFLI_S_PAUSE;
                tm_r <= 32'(PAUSE_CYC);
                phase_r <= ~phase_r & (seq_b[g] != '0);
              end
            end
            default: st_r <= SFLI_S_IDLE;
          endcase
        end
      end
      assign seq_on[g] = (st_r == SFLI_S_ON1) | (st_r == SFLI_S_ON2);
    end
  endgenerate

  // ----------------------------------------
  // status and user blink timers
  // ----------------------------------------
  logic [31:0] stat_cnt_r, user_cnt_r;
  logic stat_blink_r, user_blink_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_cnt_r <= 32'h0000_0000;
      stat_blink_r <= 1'b0;
    end
    else if (stat_cnt_r >= 32'(STAT_CYC - 1))
    begin
      stat_cnt_r <= 32'h0000_0000;
      stat_blink_r <= ~stat_blink_r;
    end
    else
      stat_cnt_r <= stat_cnt_r + 32'h0000_0001;
  end

  // user period restarts when disabled so the first flash is a full one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_cnt_r <= 32'h0000_0000;
      user_blink_r <= 1'b0;
    end
    else if (!ctrl_r[SFLI_UEN_BIT])
    begin
      user_cnt_r <= 32'h0000_0000;
      user_blink_r <= 1'b0;
    end
    else if (user_cnt_r >= uper_r)
    begin
      user_cnt_r <= 32'h0000_0000;
      user_blink_r <= ~user_blink_r;
    end
    else
      user_cnt_r <= user_cnt_r + 32'h0000_0001;
  end

  // ----------------------------------------
  // indicator outputs
  // ----------------------------------------
  logic steady, powered;
  assign steady = (mode == SFLI_M_OPER) & ctrl_r[SFLI_RUN_BIT] & ctrl_r[SFLI_LOADED_BIT] & ~fail_safe;
  assign powered = (mode != SFLI_M_OFF);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      leds <= '0;
    else
    begin
      leds.supply_status_indicator <= powered & (steady | stat_blink_r);
      leds.internal_fault_indicator <= seq_on[0];
      leds.io_fault_indicator <= seq_on[1];
      leds.user_indicator <= ctrl_r[SFLI_UEN_BIT] & ctrl_r[SFLI_UVAL_BIT] &
                             (~ctrl_r[SFLI_UFLASH_BIT] | user_blink_r);
    end
  end

  // ----------------------------------------
  // interrupts and read data
  // ----------------------------------------
  logic fs_d_r, io_d_r, oc_d_r;
  assign events = {open_circuit_fault & ~oc_d_r, io_r & ~io_d_r, fail_safe & ~fs_d_r};
  // set wins over the read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r <= '0;
      fs_d_r <= 1'b0;
      io_d_r <= 1'b0;
      oc_d_r <= 1'b0;
    end
    else
    begin
      fs_d_r <= fail_safe;
      io_d_r <= io_r;
      oc_d_r <= open_circuit_fault;
      if (rd && apb_req.paddr == SFLI_IRQ_OFS)
        irq_r <= events;
      else
        irq_r <= irq_r | events;
    end
  end
  assign irq = |(irq_r & mask_r);

  assign status_w = {20'h0, ioch_r[3:0] & 4'hf, iotype_r, io_r, query_status, low_low_force, fail_safe};

  // read mux, zero for unmapped addresses
  always_comb
  begin
    case (apb_req.paddr)
      SFLI_CTRL_OFS: prdata = ctrl_r;
      SFLI_FAULT_OFS: prdata = fault_r;
      SFLI_LATCH_OFS: prdata = latch_r;
      SFLI_STATUS_OFS: prdata = status_w;
      SFLI_IRQ_OFS: prdata = {29'h0, irq_r};
      SFLI_MASK_OFS: prdata = {29'h0, mask_r};
      SFLI_UPER_OFS: prdata = uper_r;
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

// file: tb/sfli_props.sv
// concurrent checks on the fault indicator ports
`timescale 1ns/100ps
module sfli_props
  import sfli_pkg::*;
#(
  parameter int LONG_CYC = 8,
  parameter int PAUSE_CYC = 12,
  parameter int STAT_CYC = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sfli_apb_req_type apb_req,
  input wire sfli_leds_type leds,
  input wire logic fail_safe,
  input wire logic low_low_force,
  input wire sfli_query_type query_status,
  input wire logic open_circuit_fault,
  input wire logic irq
);
  localparam int ON_LIM = PAUSE_CYC + LONG_CYC + 4;
  localparam int BLINK_LIM = STAT_CYC + 3;
  logic [31:0] ctrl_r;
  logic [31:0] fault_r;
  logic [7:0] hold_r;
  logic prev_r;
  wire logic wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  wire logic fw = wr && apb_req.paddr == SFLI_FAULT_OFS;
  wire logic steady = ctrl_r[4:0] == 5'h18 && !fail_safe;
  wire logic blink = ctrl_r[2:0] != 3'h4 && !steady;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow words; hold_r counts cycles with no green toggle, which would expose a stuck blinker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= 32'h0;
      fault_r <= 32'h0;
      hold_r <= 8'h0;
      prev_r <= 1'b0;
    end
    else
    begin
      if (wr && apb_req.paddr == SFLI_CTRL_OFS)
        ctrl_r <= apb_req.pwdata;
      if (fw)
        fault_r <= apb_req.pwdata;
      prev_r <= leds.supply_status_indicator;
      hold_r <= (blink && prev_r == leds.supply_status_indicator) ? hold_r + 8'h1 : 8'h0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_fail_enter;
    fw && apb_req.pwdata[SFLI_SELF_BIT] |-> ##2 fail_safe;
  endproperty
  a_fail_enter: assert property (p_fail_enter) else $error("no fail-safe after self fault");
  property p_query;
    fw && !fail_safe && apb_req.pwdata[0] && !apb_req.pwdata[2] |-> ##2
      query_status == ($past(apb_req.pwdata[1], 2) ? SFLI_Q_TEMP : SFLI_Q_INTERNAL);
  endproperty
  a_query: assert property (p_query) else $error("wrong query answer");
  property p_analog;
    fw && apb_req.pwdata[SFLI_AERR_BIT] |=> low_low_force;
  endproperty
  a_analog: assert property (p_analog) else $error("no low-low force");
  property p_switch;
    open_circuit_fault == fault_r[SFLI_DOSTK_BIT];
  endproperty
  a_switch: assert property (p_switch) else $error("open circuit flag wrong");
  property p_green_on;
    steady[*3] |-> leds.supply_status_indicator;
  endproperty
  a_green_on: assert property (p_green_on) else $error("green not steady");
  property p_green_blink;
    hold_r <= BLINK_LIM;
  endproperty
  a_green_blink: assert property (p_green_blink) else $error("green not flashing");
  property p_int_on;
    $rose(fail_safe) |-> ##[1:ON_LIM] leds.internal_fault_indicator;
  endproperty
  a_int_on: assert property (p_int_on) else $error("internal red not lit");
  property p_int_dark;
    (!fail_safe && !low_low_force)[*8] |-> !leds.internal_fault_indicator;
  endproperty
  a_int_dark: assert property (p_int_dark) else $error("internal red lit without fault");
  property p_user;
    (!ctrl_r[SFLI_UFLASH_BIT] && ctrl_r[2:0] != 3'h4 && $stable(ctrl_r))[*3] |->
      leds.user_indicator == (ctrl_r[SFLI_UEN_BIT] & ctrl_r[SFLI_UVAL_BIT]);
  endproperty
  a_user: assert property (p_user) else $error("user indicator wrong");
  c_io: cover property (leds.io_fault_indicator);
  c_irq: cover property (irq);
  c_user: cover property ($rose(leds.user_indicator));
endmodule
bind sfli_top sfli_props #(.LONG_CYC(LONG_CYC), .PAUSE_CYC(PAUSE_CYC), .STAT_CYC(STAT_CYC)) u_sfli_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .leds(leds), .fail_safe(fail_safe),
  .low_low_force(low_low_force), .query_status(query_status), .open_circuit_fault(open_circuit_fault),
  .irq(irq));

// file: tb/sfli_led_watch.sv
// panel indicator observer that decodes flash groups
`timescale 1ns/100ps
module sfli_led_watch
#(
  parameter int SHORT_CYC = 4
)
(
  input wire logic pclk,
  input wire logic led,
  output logic [7:0] grp_cnt,
  output logic grp_long,
  output logic [15:0] grp_num
);
  logic [7:0] pulses = 8'h0;
  logic [7:0] on_len = 8'h0;
  logic [7:0] off_len = 8'h0;
  logic was_long = 1'b0;
  logic [15:0] num_r = 16'h0;
  assign grp_num = num_r;
  // short versus long
  // an off run longer than the flash gap closes a group
  always @(posedge pclk)
  begin
    if (led)
    begin
      if (on_len == 8'h0)
        pulses <= pulses + 8'h1;
      if (on_len > SHORT_CYC)
        was_long <= 1'b1;
      on_len <= on_len + 8'h1;
      off_len <= 8'h0;
    end
    else
    begin
      on_len <= 8'h0;
      off_len <= off_len + 8'h1;
      if (off_len == SHORT_CYC + 2 && pulses != 8'h0)
      begin
        grp_cnt <= pulses;
        grp_long <= was_long;
        num_r <= num_r + 16'h1;
        pulses <= 8'h0;
        was_long <= 1'b0;
      end
    end
  end
endmodule

// file: tb/sfli_top_tb.sv
// self-checking bench for the fault indicator block
`timescale 1ns/100ps
module sfli_top_tb
  import sfli_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  sfli_apb_req_type apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, fail_safe, low_low_force, open_circuit_fault, irq;
  sfli_leds_type leds;
  sfli_query_type query_status;
  logic [7:0] int_cnt, io_cnt;
  logic int_long, io_long;
  logic [15:0] int_num, io_num;
  int bad_count = 0;
  int num_checks = 0;
  wire logic [3:0] led_v = leds;
  sfli_top #(.SHORT_CYC(4), .LONG_CYC(8), .PAUSE_CYC(12), .STAT_CYC(6), .CHAN_W(5)) u_sfli_top (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .leds(leds), .fail_safe(fail_safe), .low_low_force(low_low_force), .query_status(query_status),
    .open_circuit_fault(open_circuit_fault), .irq(irq));
  sfli_led_watch u_sfli_led_watch (.pclk(pclk), .led(leds.internal_fault_indicator), .grp_cnt(int_cnt),
    .grp_long(int_long), .grp_num(int_num));
  sfli_led_watch u_sfli_led_watch_io (.pclk(pclk), .led(leds.io_fault_indicator), .grp_cnt(io_cnt),
    .grp_long(io_long), .grp_num(io_num));
  // 40 MHz clock
  initial
    forever #12.5 pclk = ~pclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read data and error are taken at the very edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    logic ok;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      r = prdata;
      e = pslverr;
      ok = pready;
    end
    while (ok !== 1'b1);
    apb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic watch(input int b, input int n, output int ones, output int chg);
    logic last;
    ones = 0;
    chg = 0;
    @(negedge pclk);
    last = led_v[b];
    repeat (n)
    begin
      @(negedge pclk);
      ones += led_v[b];
      chg += (led_v[b] != last);
      last = led_v[b];
    end
  endtask
  task automatic grp(input logic io, output logic [7:0] n, output logic l);
    logic [15:0] n0;
    n0 = io ? io_num : int_num;
    for (int i = 0; i < 400 && (io ? io_num : int_num) == n0; i++)
      @(posedge pclk);
    #1;
    n = ((io ? io_num : int_num) == n0) ? 8'hff : (io ? io_cnt : int_cnt);
    l = io ? io_long : int_long;
  endtask
  task automatic s_clear;
    wr(SFLI_FAULT_OFS, 32'h0);
    repeat (120) @(negedge pclk);
    chk({fail_safe, leds.internal_fault_indicator}, 32'h0);
    chk(leds.io_fault_indicator, 32'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, SFLI_LATCH_OFS, 32'h0, r, e);
    chk(r, SFLI_LATCH_RST);
    apb(1'b0, SFLI_UPER_OFS, 32'h0, r, e);
    chk(r, SFLI_UPER_RST);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(SFLI_LATCH_OFS, 32'h4);
  endtask
  task automatic s_green;
    logic [7:0] fl[5] = '{8'h10, 8'h08, 8'h19, 8'h1a, 8'h1b};
    int o, c;
    wr(SFLI_CTRL_OFS, 32'h18);
    watch(3, 20, o, c);
    chk(o, 20);
    foreach (fl[i])
    begin
      wr(SFLI_CTRL_OFS, {24'h0, fl[i]});
      watch(3, 30, o, c);
      chk(c >= 4, 32'h1);
    end
    wr(SFLI_CTRL_OFS, 32'h4);
    watch(3, 10, o, c);
    chk(o, 0);
  endtask
  task automatic s_user;
    logic [7:0] cw[3] = '{8'h60, 8'h20, 8'h40};
    int ex[3] = '{10, 0, 0};
    int o, c;
    wr(SFLI_UPER_OFS, 32'h2);
    foreach (cw[i])
    begin
      wr(SFLI_CTRL_OFS, {24'h0, cw[i]});
      watch(0, 10, o, c);
      chk(o, ex[i]);
    end
    wr(SFLI_CTRL_OFS, 32'he0);
    watch(0, 20, o, c);
    chk(c >= 4, 32'h1);
  endtask
  task automatic s_int;
    logic [31:0] fw[5] = '{32'h100, 32'h3, 32'h5, 32'h61, 32'h11};
    logic [7:0] ex[5] = '{8'h1, 8'h2, 8'h3, 8'h6, 8'h4};
    logic [7:0] n;
    logic l;
    int o, c;
    wr(SFLI_CTRL_OFS, 32'h18);
    foreach (fw[i])
    begin
      wr(SFLI_FAULT_OFS, fw[i]);
      grp(1'b0, n, l);
      grp(1'b0, n, l);
      chk(n, ex[i]);
      chk(fail_safe, 32'h1);
      if (fw[i][0] && !fw[i][2])
        chk(query_status, fw[i][1] ? SFLI_Q_TEMP : SFLI_Q_INTERNAL);
      watch(3, 30, o, c);
      chk(c >= 4, 32'h1);
      s_clear();
    end
  endtask
  task automatic s_io;
    logic [7:0] n;
    logic l;
    for (int t = 1; t <= 5; t++)
    begin
      wr(SFLI_FAULT_OFS, 32'h1000 | (t << 13) | ((t % 4) << 16));
      for (int k = 0; k < 3; k++)
      begin
        grp(1'b1, n, l);
        if (!l)
          break;
      end
      chk({l, n}, t);
      grp(1'b1, n, l);
      chk({l, n}, {1'b1, 8'(t % 4 + 1)});
      s_clear();
    end
  endtask
  task automatic s_irq;
    logic [31:0] r;
    logic e;
    wr(SFLI_MASK_OFS, 32'h0);
    // drain the fail-safe and i/o events left by the earlier scenarios
    apb(1'b0, SFLI_IRQ_OFS, 32'h0, r, e);
    chk(r[2:0], 32'h3);
    wr(SFLI_FAULT_OFS, 32'h0100_0201);
    repeat (3) @(negedge pclk);
    chk({irq, low_low_force, open_circuit_fault}, 32'h3);
    apb(1'b0, SFLI_STATUS_OFS, 32'h0, r, e);
    chk(r[3:0], 32'h7);
    wr(SFLI_MASK_OFS, 32'h1);
    @(negedge pclk);
    chk(irq, 32'h1);
    apb(1'b0, SFLI_IRQ_OFS, 32'h0, r, e);
    chk(r[2:0], 32'h5);
    @(negedge pclk);
    chk(irq, 32'h0);
    s_clear();
  endtask
  task automatic s_latch;
    wr(SFLI_LATCH_OFS, 32'h14);
    wr(SFLI_FAULT_OFS, 32'h1);
    wr(SFLI_FAULT_OFS, 32'h0);
    wr(SFLI_CTRL_OFS, 32'h19);
    wr(SFLI_CTRL_OFS, 32'h18);
    @(negedge pclk);
    chk(fail_safe, 32'h1);
    repeat (20) @(negedge pclk);
    chk(fail_safe, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_green();
    s_user();
    s_int();
    s_io();
    s_irq();
    s_latch();
    test_done();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule
